/* File: verilog/opdec_pkg.sv */
// Purpose: constants and types for the instruction decoder slice
// Assumes: 16-bit opcode words, one decode per clock
// Notes: opcode values are full-word, upper-12-bit, upper-6-bit, upper-byte or upper-nibble match patterns
package opdec_pkg;

	localparam int word_w = 16;
	localparam logic [15:0] op_pop_acc = 16'hBE32;
	localparam logic [15:0] op_push_acc = 16'hBE3C;
	localparam logic [15:0] op_ret = 16'hEF00;
	localparam logic [15:0] op_prod_sub = 16'hBE05;
	localparam logic [15:0] op_xor_k16 = 16'hBE83;
	localparam logic [11:0] op_mode_set_hi = 12'hBE4;
	localparam logic [5:0] op_cond_ret_hi = 6'b1110_11;
	localparam logic [11:0] op_sub_lk_hi = 12'hBFA;
	localparam logic [11:0] op_xor_lk_hi = 12'hBFD;
	localparam logic [7:0] ub_pop_mem = 8'h8A;
	localparam logic [7:0] ub_push_mem = 8'h76;
	localparam logic [7:0] ub_repeat_imm = 8'hBB;
	localparam logic [7:0] ub_repeat_mem = 8'h0B;
	localparam logic [3:0] nb_store_acc = 4'h9;
	localparam logic [7:0] ub_aux_sub = 8'h7C;
	localparam logic [7:0] ub_product_mode = 8'hBF;
	localparam logic [7:0] ub_square_acc = 8'h52;
	localparam logic [7:0] ub_square_sub = 8'h53;
	localparam logic [7:0] ub_status_zero = 8'h8E;
	localparam logic [7:0] ub_status_one = 8'h8F;
	localparam logic [7:0] ub_long_store = 8'hAE;
	localparam logic [3:0] nb_sub_shift = 4'h3;
	localparam logic [7:0] ub_sub_high = 8'h65;
	localparam logic [7:0] ub_sub_borrow = 8'h64;
	localparam logic [7:0] ub_sub_unext = 8'h66;
	localparam logic [7:0] ub_sub_cond = 8'h0A;
	localparam logic [7:0] ub_sub_temp = 8'h67;
	localparam logic [7:0] ub_sub_short = 8'hBA;
	localparam logic [7:0] ub_rounded_load = 8'h68;
	localparam logic [3:0] mb_carry = 4'hF;
	localparam logic [3:0] mb_block = 4'h5;
	localparam logic [3:0] mb_intm = 4'h1;
	localparam logic [3:0] mb_ovm = 4'h3;
	localparam logic [3:0] mb_test = 4'hB;
	localparam logic [3:0] mb_ext_flag = 4'hD;
	localparam logic [3:0] mb_sxm = 4'h7;
	localparam logic [2:0] cyc_one = 3'h1;
	localparam logic [2:0] cyc_two = 3'h2;
	localparam logic [2:0] cyc_ret = 3'h4;
	localparam logic [2:0] cyc_ret_not = 3'h2;

	typedef enum logic [5:0] {
		op_none,
		op_pop_to_acc,
		op_pop_to_memory,
		op_push_from_memory,
		op_push_from_acc,
		op_return,
		op_conditional_return,
		op_repeat_imm,
		op_repeat_mem,
		op_store_high_acc_shifted,
		op_store_low_acc_shifted,
		op_aux_reg_short_subtract,
		op_set_mode_bit,
		op_product_subtract,
		op_product_shift_mode_set,
		op_square_accumulate,
		op_square_subtract,
		op_status_store_zero,
		op_status_store_one,
		op_long_immediate_store,
		op_sub_shifted,
		op_sub_long_imm,
		op_sub_high,
		op_subtract_with_borrow,
		op_unextended_low_subtract,
		op_conditional_subtract_step,
		op_temp_shift_subtract,
		op_sub_short_imm,
		op_xor_long_imm,
		op_xor_long_16,
		op_rounded_high_load
	} op_kind_t;

	typedef struct packed {
		op_kind_t kind;
		logic [2:0] cycles;
		logic second_word;
		logic [7:0] field8;
		logic [3:0] shift;
		logic [6:0] mode_bits;
		logic [7:0] cond;
	} dec_out_t;

	typedef struct packed {
		logic valid;
		logic [15:0] word;
	} fetch_t;

endpackage : opdec_pkg

/* File: verilog/dsp_opcode_decode.sv */
// Purpose: decode one slice of the core instruction set into control actions
// Assumes: fetch presents one program word per valid cycle, inputs synchronous
// Notes: unknown opcodes decode as op_none with illegal_op set
`timescale 1ns/1ps
module dsp_opcode_decode import opdec_pkg::*; #(
	parameter int opcode_w = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire fetch_t fetch,
	input wire logic cond_true,
	output dec_out_t dec,
	output logic dec_valid,
	output logic illegal_op,
	output logic [15:0] constant_word,
	output logic constant_valid,
	output logic expect_second
);

	// the match patterns are fixed 16-bit words, so no other width can be served
	if (opcode_w != word_w) begin : g_bad_width
		$error("opcode width must be 16");
	end

	////////////////////////////////////////////////////////////////////
	// decode of the current word
	function automatic dec_out_t decode(input logic [15:0] w, input logic ct);
		dec_out_t d;
		logic [7:0] ub;
		d = '0;
		d.kind = op_none;
		d.cycles = cyc_one;
		ub = w[15:8];
		d.field8 = w[7:0];
		d.shift = w[3:0];
		if (w == op_pop_acc) begin
			d.kind = op_pop_to_acc;
		end else if (w == op_push_acc) begin
			d.kind = op_push_from_acc;
		end else if (w == op_prod_sub) begin
			d.kind = op_product_subtract;
		end else if (w == op_ret) begin
			d.kind = op_return;
			d.cycles = cyc_ret;
		end else if (w[15:10] == op_cond_ret_hi) begin
			d.kind = op_conditional_return;
			d.cond = w[9:2];
			d.cycles = ct ? cyc_ret : cyc_ret_not;
		end else if (w == op_xor_k16) begin
			d.kind = op_xor_long_16;
			d.second_word = 1'b1;
			d.cycles = cyc_two;
		end else if (w[15:4] == op_mode_set_hi) begin
			d.kind = op_set_mode_bit;
			d.mode_bits[0] = (w[3:0] == mb_carry);
			d.mode_bits[1] = (w[3:0] == mb_block);
			d.mode_bits[2] = (w[3:0] == mb_intm);
			d.mode_bits[3] = (w[3:0] == mb_ovm);
			d.mode_bits[4] = (w[3:0] == mb_test);
			d.mode_bits[5] = (w[3:0] == mb_ext_flag);
			d.mode_bits[6] = (w[3:0] == mb_sxm);
			if (d.mode_bits == 7'h00) begin
				d.kind = op_none;
			end
		end else if (w[15:4] == op_sub_lk_hi) begin
			d.kind = op_sub_long_imm;
			d.second_word = 1'b1;
			d.cycles = cyc_two;
		end else if (w[15:4] == op_xor_lk_hi) begin
			d.kind = op_xor_long_imm;
			d.second_word = 1'b1;
			d.cycles = cyc_two;
		end else if (ub == ub_product_mode) begin
			// every other 0xBF form decodes here, with the shift taken from bits 1:0
			d.kind = op_product_shift_mode_set;
			d.shift = {2'b00, w[1:0]};
		end else if (ub == ub_pop_mem) begin
			d.kind = op_pop_to_memory;
		end else if (ub == ub_push_mem) begin
			d.kind = op_push_from_memory;
		end else if (ub == ub_repeat_imm) begin
			d.kind = op_repeat_imm;
		end else if (ub == ub_repeat_mem) begin
			d.kind = op_repeat_mem;
		end else if (w[15:12] == nb_store_acc) begin
			d.kind = w[11] ? op_store_high_acc_shifted : op_store_low_acc_shifted;
			d.shift = {1'b0, w[10:8]};
		end else if (ub == ub_aux_sub) begin
			d.kind = op_aux_reg_short_subtract;
		end else if (ub == ub_square_acc) begin
			d.kind = op_square_accumulate;
		end else if (ub == ub_square_sub) begin
			d.kind = op_square_subtract;
		end else if (ub == ub_status_zero) begin
			d.kind = op_status_store_zero;
		end else if (ub == ub_status_one) begin
			d.kind = op_status_store_one;
		end else if (ub == ub_long_store) begin
			d.kind = op_long_immediate_store;
			d.second_word = 1'b1;
			d.cycles = cyc_two;
		end else if (w[15:12] == nb_sub_shift) begin
			d.kind = op_sub_shifted;
			d.shift = w[11:8];
		end else if (ub == ub_sub_high) begin
			d.kind = op_sub_high;
		end else if (ub == ub_sub_borrow) begin
			d.kind = op_subtract_with_borrow;
		end else if (ub == ub_sub_unext) begin
			d.kind = op_unextended_low_subtract;
		end else if (ub == ub_sub_cond) begin
			d.kind = op_conditional_subtract_step;
		end else if (ub == ub_sub_temp) begin
			d.kind = op_temp_shift_subtract;
		end else if (ub == ub_sub_short) begin
			d.kind = op_sub_short_imm;
		end else if (ub == ub_rounded_load) begin
			d.kind = op_rounded_high_load;
		end
		return d;
	endfunction : decode

	////////////////////////////////////////////////////////////////////
	// datapath
	logic expect_r;
	logic expect_nxt;
	dec_out_t dec_r;
	dec_out_t dec_nxt;
	logic dec_valid_r;
	logic illegal_r;
	logic [15:0] const_r;
	logic const_valid_r;
	dec_out_t cur;
	wire take_op = fetch.valid && !expect_r;
	wire take_const = fetch.valid && expect_r;

	// the constant word is decoded but its result is never taken, so it cannot alias an opcode
	assign cur = decode(fetch.word, cond_true);
	assign expect_nxt = take_op ? cur.second_word : (take_const ? 1'b0 : expect_r);
	assign dec_nxt = take_op ? cur : dec_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			expect_r <= 1'b0;
			dec_r <= '0;
			dec_valid_r <= 1'b0;
			illegal_r <= 1'b0;
			const_r <= 16'h0000;
			const_valid_r <= 1'b0;
		end else begin
			expect_r <= expect_nxt;
			dec_r <= dec_nxt;
			dec_valid_r <= take_op;
			illegal_r <= take_op && (cur.kind == op_none);
			const_r <= take_const ? fetch.word : const_r;
			const_valid_r <= take_const;
		end
	end

	assign dec = dec_r;
	assign dec_valid = dec_valid_r;
	assign illegal_op = illegal_r;
	assign constant_word = const_r;
	assign constant_valid = const_valid_r;
	assign expect_second = expect_r;

endmodule : dsp_opcode_decode

/* File: verif/opdec_checker.sv */
// Purpose: port checks for the decoder slice
// Assumes: one clock, synchronous reset
// Notes: each decode is tied to the word taken one edge earlier
`timescale 1ns/1ps
module opdec_checker import opdec_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire fetch_t fetch,
	input wire logic cond_true,
	input wire dec_out_t dec,
	input wire logic dec_valid,
	input wire logic illegal_op,
	input wire logic [15:0] constant_word,
	input wire logic constant_valid,
	input wire logic expect_second
);
	wire logic take = fetch.valid && !expect_second;
	wire logic [15:0] w = fetch.word;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	a_pop_acc_kind: assert property (
		take && w == op_pop_acc |=> dec_valid && dec.kind == op_pop_to_acc)
		else $error("pop to accumulator decode wrong");
	a_ret_cycles: assert property (
		take && w == op_ret |=> dec.kind == op_return && dec.cycles == cyc_ret)
		else $error("return decode wrong");
	a_cond_ret_cycles: assert property (
		take && w[15:10] == op_cond_ret_hi && w != op_ret
		|=> dec.cycles == ($past(cond_true) ? cyc_ret : cyc_ret_not)) else $error("cond return cycles");
	a_store_half_sel: assert property (
		take && w[15:12] == nb_store_acc |=> dec.kind == ($past(w[11]) ?
		op_store_high_acc_shifted : op_store_low_acc_shifted)) else $error("store half wrong");
	a_sub_shift_field: assert property (
		take && w[15:12] == nb_sub_shift |=> dec.kind == op_sub_shifted && dec.shift == $past(w[11:8]))
		else $error("shifted subtract wrong");
	a_flag_mode_bit: assert property (
		take && w == {op_mode_set_hi, mb_ext_flag} |=> dec.kind == op_set_mode_bit
		&& dec.mode_bits == 7'h20)
		else $error("flag mode bit wrong");
	a_long_store_pairing: assert property (
		take && w[15:8] == ub_long_store |=> dec.kind == op_long_immediate_store && expect_second)
		else $error("long store not paired");
	a_two_word_flag: assert property (
		dec_valid && dec.second_word |-> expect_second && dec.cycles == cyc_two)
		else $error("two word flag wrong");
	a_const_not_opcode: assert property (
		fetch.valid && expect_second |=> constant_valid && !dec_valid && constant_word == $past(w))
		else $error("constant word decoded");
endmodule : opdec_checker

/* File: verif/fetch_model.sv */
// Purpose: program fetch side feeding words to the decoder
// Assumes: words change only at the falling edge
// Notes: a released word bus shows the inverse, never a stale word
`timescale 1ns/1ps
module fetch_model import opdec_pkg::*; (
	input wire logic clk,
	output fetch_t fetch
);
	initial fetch = '{valid: 1'b0, word: 16'h0000};
	task automatic send(input logic [15:0] word);
		@(negedge clk);
		fetch <= '{valid: 1'b1, word: word};
	endtask : send
	// stalls model a slow fetch between opcode and constant
	task automatic idle(input int n);
		@(negedge clk);
		fetch <= '{valid: 1'b0, word: ~fetch.word};
		repeat (n) @(negedge clk);
	endtask : idle
endmodule : fetch_model

/* File: verif/tb_top.sv */
// Purpose: self-checking bench for the decoder slice
// Assumes: inputs change at the falling edge
// Notes: constants are decodable opcodes to catch a missed pairing
`timescale 1ns/1ps
module tb_top import opdec_pkg::*; ();
	logic clk, rst, cond_true, dec_valid, illegal_op, constant_valid, expect_second;
	logic [15:0] constant_word;
	fetch_t fetch;
	dec_out_t dec;
	int fail_count = 0;
	int check_count = 0;
	dsp_opcode_decode dsp_opcode_decode_i (.clk(clk), .rst(rst), .fetch(fetch),
		.cond_true(cond_true), .dec(dec), .dec_valid(dec_valid), .illegal_op(illegal_op),
		.constant_word(constant_word), .constant_valid(constant_valid),
		.expect_second(expect_second));
	fetch_model fetch_model_i (.clk(clk), .fetch(fetch));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_kind(input op_kind_t got, input op_kind_t exp);
		chk({10'h000, got}, {10'h000, exp});
	endtask : chk_kind
	task automatic test_done;
		$display("mismatches %0d comparisons %0d", fail_count, check_count);
		if (fail_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	////////////////////////////////////////////////////////////////
	task automatic t_table;
		logic [15:0] w[25] = '{16'hBE32, 16'h8A05, 16'h7611, 16'hBE3C, 16'hEF00, 16'hBB07,
			16'h0B03, 16'h9A10, 16'h9310, 16'h7C44, 16'hBE05, 16'hBF02, 16'h5201, 16'h5301,
			16'h8E01, 16'h8F01, 16'h3512, 16'h6501, 16'h6401, 16'h6601, 16'h0A01, 16'h6701,
			16'hBA09, 16'h6801, 16'hBE02};
		op_kind_t k[25] = '{op_pop_to_acc, op_pop_to_memory, op_push_from_memory,
			op_push_from_acc, op_return, op_repeat_imm, op_repeat_mem, op_store_high_acc_shifted,
			op_store_low_acc_shifted, op_aux_reg_short_subtract, op_product_subtract,
			op_product_shift_mode_set, op_square_accumulate, op_square_subtract,
			op_status_store_zero, op_status_store_one, op_sub_shifted, op_sub_high,
			op_subtract_with_borrow, op_unextended_low_subtract, op_conditional_subtract_step,
			op_temp_shift_subtract, op_sub_short_imm, op_rounded_high_load, op_none};
		foreach (w[i]) begin
			fetch_model_i.send(w[i]);
			fetch_model_i.idle(0);
			chk_kind(dec.kind, k[i]);
			chk({13'h0000, dec.cycles}, {13'h0000, (w[i] == op_ret) ? cyc_ret : cyc_one});
			chk({dec.field8, 7'h00, illegal_op}, {w[i][7:0], 7'h00, k[i] == op_none});
		end
	endtask : t_table
	task automatic t_set_mode_bit;
		logic [3:0] nb[7] = '{4'hF, 4'h5, 4'h1, 4'h3, 4'hB, 4'hD, 4'h7};
		foreach (nb[i]) begin
			fetch_model_i.send({op_mode_set_hi, nb[i]});
			fetch_model_i.idle(0);
			chk({9'h000, dec.mode_bits}, 16'h0001 << i);
		end
	endtask : t_set_mode_bit
	task automatic t_cond;
		for (int c = 0; c < 2; c++) begin
			cond_true = c[0];
			fetch_model_i.send(16'hEC55);
			fetch_model_i.idle(0);
			chk({5'h00, dec.cycles, dec.cond}, {5'h00, c[0] ? cyc_ret : cyc_ret_not, 8'h15});
		end
	endtask : t_cond
	task automatic t_pair;
		logic [15:0] op[4] = '{16'hAE12, 16'hBFA3, 16'hBFD5, 16'hBE83};
		logic [15:0] k[4] = '{16'hBE32, 16'h3512, 16'h7C44, 16'hAE00};
		op_kind_t ek[4] = '{op_long_immediate_store, op_sub_long_imm, op_xor_long_imm, op_xor_long_16};
		foreach (op[i]) begin
			fetch_model_i.send(op[i]);
			if (i > 0) fetch_model_i.idle(i - 1);
			fetch_model_i.send(k[i]);
			chk({12'h000, dec.cycles, expect_second}, {12'h000, cyc_two, 1'b1});
			fetch_model_i.idle(0);
			chk(constant_word, k[i]);
			chk({14'h0000, constant_valid, expect_second}, 16'h0002);
			chk_kind(dec.kind, ek[i]);
		end
	endtask : t_pair
	initial begin
		rst = 1'b1;
		cond_true = 1'b0;
		repeat (6) @(negedge clk);
		chk({dec_valid, expect_second, constant_valid, illegal_op, 6'h00, dec.kind}, 16'h0000);
		rst = 1'b0;
		t_table;
		t_set_mode_bit;
		t_cond;
		t_pair;
		test_done;
	end
	// generous bound: the whole sequence needs under a hundred cycles
	initial begin
		#(3000 * 5);
		fail_count++;
		test_done;
	end
endmodule : tb_top
bind dsp_opcode_decode opdec_checker opdec_checker_i (.clk(clk), .rst(rst), .fetch(fetch),
	.cond_true(cond_true), .dec(dec), .dec_valid(dec_valid), .illegal_op(illegal_op),
	.constant_word(constant_word), .constant_valid(constant_valid), .expect_second(expect_second));
